// ==== core/bcc_clock.sv ====
// BCD calendar clock with alarm comparator and AHB-Lite register slave
// Behaviour
// - Stop counting at 23:59:59 12/31/1999
// - February gains a day in leap years
// - Hours run 00 to 23, no AM/PM
// - Weekday advances on day rollover, wraps Saturday
// - Date and time fields are packed BCD bytes
// - Weekday binary, Sunday 0 to Saturday 6
// - Alarm type code 0 to 3
// - Alarm write clears flag; event sets it
// - Alarm read returns flag then clears it
// - Read-time returns all seven time fields
// - All-ones digit on set keeps old digit
// - No event until enable command issued
// - Disable stops events; rewrite alarm, then enable
// - Alarm write stores all fields except year
// - Compare ignores year and seconds units
// - All-ones alarm digit matches any value
// - Alarm read gives year FF, seconds units F
// - Unknown command codes do nothing
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bcc_clock #(
  parameter int TICK_CYCLES = bcc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Alarm event towards the system
  output logic o_alarm_event,
  output logic [7:0] o_alarm_type,
  output logic [15:0] o_alarm_addr
);
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] keep_wild(input logic [7:0] nv, input logic [7:0] ov);
    keep_wild = {(nv[7:4] == bcc_pkg::NIB_WILD) ? ov[7:4] : nv[7:4],
                 (nv[3:0] == bcc_pkg::NIB_WILD) ? ov[3:0] : nv[3:0]};
  endfunction

  function automatic logic nib_ok(input logic [3:0] a, input logic [3:0] c);
    nib_ok = (a == bcc_pkg::NIB_WILD) || (a == c);
  endfunction

  function automatic logic byte_ok(input logic [7:0] a, input logic [7:0] c);
    byte_ok = nib_ok(a[7:4], c[7:4]) && nib_ok(a[3:0], c[3:0]);
  endfunction

  // Century year 00 (1900) is not a leap year
  function automatic logic [7:0] last_day(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : ((yr[3:0] == 4'h4 || yr[3:0] == 4'h8) || (yr[3:0] == 4'h0 && yr[7:4] != 4'h0));
    case (mo)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = bcc_pkg::MAX_DAY;
    endcase
  endfunction

  // Time, alarm and descriptor state
  logic [7:0] yr_reg, mo_reg, dy_reg, hr_reg, mi_reg, se_reg, wd_reg;
  logic [7:0] a_mo_reg, a_dy_reg, a_hr_reg, a_mi_reg, a_se_reg, a_wd_reg, a_type_reg;
  logic [15:0] a_addr_reg;
  logic en_reg, valid_reg, flag_reg, match_prev_reg, tick_d_reg;
  logic [31:0] d_date_reg, d_time_reg, d_xtra_reg;
  logic [7:0] addr_reg;
  logic wr_reg, rd_wait_reg;
  logic [31:0] rdata_reg;
  logic tick;

  bcc_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .o_tick(tick)
  );

  // Bus decode; reads take one wait state so they see command results
  wire logic take = i_hsel && i_htrans[1] && i_hready;
  wire logic bus_wr = wr_reg && !rd_wait_reg;
  wire logic wr_cmd = bus_wr && (addr_reg == bcc_pkg::OFF_CMD);
  wire logic [7:0] code = i_hwdata[7:0];
  wire logic c_rtime = wr_cmd && (code == bcc_pkg::CMD_READ_TIME);
  wire logic c_stime = wr_cmd && (code == bcc_pkg::CMD_SET_TIME);
  wire logic c_en = wr_cmd && (code == bcc_pkg::CMD_ENABLE);
  wire logic c_dis = wr_cmd && (code == bcc_pkg::CMD_DISABLE);
  wire logic c_salarm = wr_cmd && (code == bcc_pkg::CMD_SET_ALARM);
  wire logic c_ralarm = wr_cmd && (code == bcc_pkg::CMD_READ_ALARM);
  wire logic c_any = c_rtime || c_stime || c_en || c_dis || c_salarm || c_ralarm;

  // Descriptor bytes in packed BCD
  wire logic [7:0] d_yr = d_date_reg[31:24];
  wire logic [7:0] d_mo = d_date_reg[23:16];
  wire logic [7:0] d_dy = d_date_reg[15:8];
  wire logic [7:0] d_hr = d_date_reg[7:0];
  wire logic [7:0] d_mi = d_time_reg[31:24];
  wire logic [7:0] d_se = d_time_reg[23:16];
  wire logic [7:0] d_wd = d_time_reg[15:8];
  wire logic [7:0] d_ty = d_time_reg[7:0];

  // Calendar carry chain
  wire logic at_max = (yr_reg == bcc_pkg::MAX_YEAR) && (mo_reg == bcc_pkg::MAX_MONTH)
    && (dy_reg == bcc_pkg::MAX_DAY) && (hr_reg == bcc_pkg::MAX_HOUR)
    && (mi_reg == bcc_pkg::MAX_SEC) && (se_reg == bcc_pkg::MAX_SEC);
  wire logic run = tick && !at_max;
  wire logic c_mi = run && (se_reg == bcc_pkg::MAX_SEC);
  wire logic c_hr = c_mi && (mi_reg == bcc_pkg::MAX_SEC);
  wire logic c_dy = c_hr && (hr_reg == bcc_pkg::MAX_HOUR);
  wire logic c_mo = c_dy && (dy_reg == last_day(mo_reg, yr_reg));
  wire logic c_yr = c_mo && (mo_reg == bcc_pkg::MAX_MONTH);

  wire logic [7:0] se_step = c_mi ? bcc_pkg::RST_TIME : bcd_inc(se_reg);
  wire logic [7:0] mi_step = c_hr ? bcc_pkg::RST_TIME : bcd_inc(mi_reg);
  wire logic [7:0] hr_step = c_dy ? bcc_pkg::RST_TIME : bcd_inc(hr_reg);
  wire logic [7:0] dy_step = c_mo ? bcc_pkg::RST_DAY : bcd_inc(dy_reg);
  wire logic [7:0] mo_step = c_yr ? bcc_pkg::RST_MONTH : bcd_inc(mo_reg);
  wire logic [7:0] wd_step = (wd_reg == bcc_pkg::MAX_WDAY) ? 8'h00 : wd_reg + 8'h01;

  // Set-time wins over the tick in the same cycle
  wire logic [7:0] se_next = c_stime ? keep_wild(d_se, se_reg) : run ? se_step : se_reg;
  wire logic [7:0] mi_next = c_stime ? keep_wild(d_mi, mi_reg) : c_mi ? mi_step : mi_reg;
  wire logic [7:0] hr_next = c_stime ? keep_wild(d_hr, hr_reg) : c_hr ? hr_step : hr_reg;
  wire logic [7:0] dy_next = c_stime ? keep_wild(d_dy, dy_reg) : c_dy ? dy_step : dy_reg;
  wire logic [7:0] mo_next = c_stime ? keep_wild(d_mo, mo_reg) : c_mo ? mo_step : mo_reg;
  wire logic [7:0] yr_next = c_stime ? keep_wild(d_yr, yr_reg) : c_yr ? bcd_inc(yr_reg) : yr_reg;
  wire logic [7:0] wd_next = c_stime ? keep_wild(d_wd, wd_reg) : c_dy ? wd_step : wd_reg;

  // Alarm compare one cycle after the tick, on the updated time
  wire logic match = byte_ok(a_mo_reg, mo_reg) && byte_ok(a_dy_reg, dy_reg)
    && byte_ok(a_hr_reg, hr_reg) && byte_ok(a_mi_reg, mi_reg)
    && nib_ok(a_se_reg[7:4], se_reg[7:4]) && byte_ok(a_wd_reg, wd_reg);
  // Edge of match so a ten-second window fires only once
  wire logic fire = tick_d_reg && en_reg && valid_reg && match && !match_prev_reg;

  // Event set wins over the read or write clear
  wire logic flag_next = fire ? 1'b1 : (c_salarm || c_ralarm) ? 1'b0 : flag_reg;
  wire logic en_next = c_dis ? 1'b0 : c_en ? valid_reg : en_reg;
  wire logic valid_next = c_dis ? 1'b0 : c_salarm ? 1'b1 : valid_reg;
  wire logic [7:0] stat_byte = flag_reg ? bcc_pkg::STAT_FIRED : bcc_pkg::STAT_IDLE;

  // Descriptor next values: bus writes or command results
  wire logic [31:0] d_date_next =
    c_rtime ? {yr_reg, mo_reg, dy_reg, hr_reg} :
    c_ralarm ? {bcc_pkg::BYTE_WILD, a_mo_reg, a_dy_reg, a_hr_reg} :
    (bus_wr && addr_reg == bcc_pkg::OFF_DESC_DATE) ? i_hwdata : d_date_reg;
  wire logic [31:0] d_time_next =
    c_rtime ? {mi_reg, se_reg, wd_reg, d_ty} :
    c_ralarm ? {a_mi_reg, a_se_reg[7:4], bcc_pkg::NIB_WILD, a_wd_reg, a_type_reg} :
    (bus_wr && addr_reg == bcc_pkg::OFF_DESC_TIME) ? i_hwdata : d_time_reg;
  wire logic [31:0] d_xtra_next =
    c_ralarm ? {8'h00, stat_byte, a_addr_reg} :
    (bus_wr && addr_reg == bcc_pkg::OFF_DESC_XTRA) ? {8'h00, 8'h00, i_hwdata[15:0]} : d_xtra_reg;

  // Read mux; unmapped offsets read zero
  wire logic [31:0] rd_mux =
    (addr_reg == bcc_pkg::OFF_DESC_DATE) ? d_date_reg :
    (addr_reg == bcc_pkg::OFF_DESC_TIME) ? d_time_reg :
    (addr_reg == bcc_pkg::OFF_DESC_XTRA) ? d_xtra_reg :
    (addr_reg == bcc_pkg::OFF_NOW_DATE) ? {yr_reg, mo_reg, dy_reg, hr_reg} :
    (addr_reg == bcc_pkg::OFF_NOW_TIME) ? {mi_reg, se_reg, wd_reg, 8'h00} :
    (addr_reg == bcc_pkg::OFF_STATE) ? {29'h0, flag_reg, valid_reg, en_reg} :
    bcc_pkg::RST_WORD;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      rdata_reg <= bcc_pkg::RST_WORD;
    end
    else
    begin
      addr_reg <= take ? i_haddr[7:0] : addr_reg;
      wr_reg <= take && i_hwrite;
      rd_wait_reg <= take && !i_hwrite;
      rdata_reg <= rd_wait_reg ? rd_mux : rdata_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      yr_reg <= bcc_pkg::RST_YEAR;
      mo_reg <= bcc_pkg::RST_MONTH;
      dy_reg <= bcc_pkg::RST_DAY;
      hr_reg <= bcc_pkg::RST_TIME;
      mi_reg <= bcc_pkg::RST_TIME;
      se_reg <= bcc_pkg::RST_TIME;
      wd_reg <= bcc_pkg::RST_TIME;
      d_date_reg <= bcc_pkg::RST_WORD;
      d_time_reg <= bcc_pkg::RST_WORD;
      d_xtra_reg <= bcc_pkg::RST_WORD;
    end
    else
    begin
      yr_reg <= yr_next;
      mo_reg <= mo_next;
      dy_reg <= dy_next;
      hr_reg <= hr_next;
      mi_reg <= mi_next;
      se_reg <= se_next;
      wd_reg <= wd_next;
      d_date_reg <= d_date_next;
      d_time_reg <= d_time_next;
      d_xtra_reg <= d_xtra_next;
    end
  end

  // Alarm store: year is never kept
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      a_mo_reg <= bcc_pkg::RST_WORD[7:0];
      a_dy_reg <= bcc_pkg::RST_WORD[7:0];
      a_hr_reg <= bcc_pkg::RST_WORD[7:0];
      a_mi_reg <= bcc_pkg::RST_WORD[7:0];
      a_se_reg <= bcc_pkg::RST_WORD[7:0];
      a_wd_reg <= bcc_pkg::RST_WORD[7:0];
      a_type_reg <= bcc_pkg::TYPE_NONE;
      a_addr_reg <= 16'h0000;
    end
    else if (c_salarm)
    begin
      a_mo_reg <= d_mo;
      a_dy_reg <= d_dy;
      a_hr_reg <= d_hr;
      a_mi_reg <= d_mi;
      a_se_reg <= d_se;
      a_wd_reg <= d_wd;
      a_type_reg <= d_ty;
      a_addr_reg <= d_xtra_reg[15:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      en_reg <= 1'b0;
      valid_reg <= 1'b0;
      flag_reg <= 1'b0;
      match_prev_reg <= 1'b0;
      tick_d_reg <= 1'b0;
      o_alarm_event <= 1'b0;
    end
    else
    begin
      en_reg <= en_next;
      valid_reg <= valid_next;
      flag_reg <= flag_next;
      match_prev_reg <= tick_d_reg ? match : match_prev_reg;
      tick_d_reg <= tick;
      o_alarm_event <= fire;
    end
  end

  assign o_hrdata = rdata_reg;
  assign o_hreadyout = !rd_wait_reg;
  assign o_hresp = 1'b0;
  assign o_alarm_type = a_type_reg;
  assign o_alarm_addr = a_addr_reg;

  a_event_sets_flag:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n) fire |=> flag_reg)
    else $error("flag not set by alarm event");
  a_alarm_write_clears:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (c_salarm && !fire) |=> (!flag_reg && valid_reg))
    else $error("alarm write did not clear flag");
  a_read_returns_flag:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (c_ralarm && flag_reg && !fire) |=> (d_xtra_reg[23:16] == 8'h01 && !flag_reg))
    else $error("alarm read did not return and clear flag");
  a_no_fire_disabled:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n) !en_reg |=> !o_alarm_event)
    else $error("event while disabled");
  a_disable_stops:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (c_dis ##1 (!c_salarm && !c_dis) [*2]) |-> (!en_reg && !fire))
    else $error("event possible after disable");
  a_stop_at_max:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (at_max && !c_stime) |=> (se_reg == 8'h59 && yr_reg == 8'h99))
    else $error("clock ran past final second");
  a_hour_wraps:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (c_dy && !c_stime) |=> (hr_reg == 8'h00 && se_reg == 8'h00))
    else $error("hour did not wrap to zero");
  a_weekday_step:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (c_dy && !c_stime && wd_reg == 8'h06) |=> (wd_reg == 8'h00))
    else $error("weekday did not wrap after Saturday");
  a_unknown_cmd_idle:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (wr_cmd && !c_any) |=> ($stable(d_date_reg) && $stable(en_reg) && $stable(valid_reg)))
    else $error("unknown command had an effect");
  a_fire_once:
    assert property (@(posedge i_core_clk) disable iff (!i_arst_n) fire |=> !fire [*8])
    else $error("alarm fired twice in a row");
endmodule
`default_nettype wire

// ==== include/bcc_pkg.sv ====
// Package: constants for the BCD calendar clock with alarm
package bcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_DESC_DATE = 8'h04;
  localparam logic [7:0] OFF_DESC_TIME = 8'h08;
  localparam logic [7:0] OFF_DESC_XTRA = 8'h0C;
  localparam logic [7:0] OFF_NOW_DATE = 8'h10;
  localparam logic [7:0] OFF_NOW_TIME = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;
  // Command codes
  localparam logic [7:0] CMD_READ_TIME = 8'h00;
  localparam logic [7:0] CMD_SET_TIME = 8'hFF;
  localparam logic [7:0] CMD_ENABLE = 8'h80;
  localparam logic [7:0] CMD_DISABLE = 8'h81;
  localparam logic [7:0] CMD_SET_ALARM = 8'h82;
  localparam logic [7:0] CMD_READ_ALARM = 8'h84;
  // Alarm types
  localparam logic [7:0] TYPE_NONE = 8'h00;
  localparam logic [7:0] TYPE_MESSAGE = 8'h01;
  localparam logic [7:0] TYPE_NAMED_FUNCTION_WAKE = 8'h02;
  localparam logic [7:0] TYPE_ROUTINE_CALL_WAKE = 8'h03;
  // Status byte values
  localparam logic [7:0] STAT_IDLE = 8'h00;
  localparam logic [7:0] STAT_FIRED = 8'h01;
  // Digit constants
  localparam logic [3:0] NIB_WILD = 4'hF;
  localparam logic [7:0] BYTE_WILD = 8'hFF;
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [7:0] MAX_DAY = 8'h31;
  localparam logic [7:0] MAX_WDAY = 8'h06;
  // Reset values
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_TIME = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SECOND_NS = 1000000000;
  localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
endpackage

// ==== core/bcc_tick.sv ====
// Seconds prescaler for the calendar clock
`timescale 1ns/1ps
`default_nettype none
module bcc_tick #(
  parameter int CYCLES = 25000000
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Tick out
  output logic o_tick
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  wire logic at_last = (cnt_reg == LAST);
  wire logic [CW-1:0] cnt_next = at_last ? '0 : cnt_reg + CW'(1);

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_reg <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      o_tick <= at_last;
    end
  end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the BCD calendar clock with alarm
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TICKS = 8;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] ST_D [4] = '{32'h9602_2823, 32'h9702_2823, 32'h0002_2823, 32'h9912_3123};
  localparam logic [31:0] EX_D [4] = '{32'h9602_2900, 32'h9703_0100, 32'h0003_0100, 32'h9912_3123};
  logic i_core_clk;
  logic i_arst_n;
  logic i_hsel;
  logic [31:0] i_haddr;
  logic [1:0] i_htrans;
  logic i_hwrite;
  logic [2:0] i_hsize;
  logic [31:0] i_hwdata;
  wire logic [31:0] o_hrdata;
  wire logic o_hreadyout;
  wire logic o_hresp;
  wire logic o_alarm_event;
  wire logic [7:0] o_alarm_type;
  wire logic [15:0] o_alarm_addr;
  int miscompares = 0;
  int comparisons = 0;
  int events = 0;
  logic [15:0] aaddr;
  logic [31:0] desc;
  logic [7:0] code;

  // Single slave, so its ready output is the bus ready
  bcc_clock #(.TICK_CYCLES(TICKS)) bcc_clock_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hready(o_hreadyout), .i_hwdata(i_hwdata), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_alarm_event(o_alarm_event),
    .o_alarm_type(o_alarm_type), .o_alarm_addr(o_alarm_addr));

  initial
  begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk)
  begin
    if (i_arst_n === 1'b1 && o_alarm_event === 1'b1)
      events <= events + 1;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input logic [31:0] mask, input string what);
    comparisons++;
    if ((got & mask) !== (exp & mask))
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got & mask, exp & mask);
    end
  endtask

  task automatic chk_count(input int exp, input string what);
    comparisons++;
    if (events != exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %0d events want %0d", $time, what, events, exp);
    end
  endtask

  // Ready is stable between edges, so the falling edge shows what the next rise samples
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge i_core_clk);
    while (o_hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        miscompares++;
        wrap_up();
      end
      @(negedge i_core_clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    i_hsel <= 1'b1;
    i_haddr <= {24'h00_0000, a};
    i_htrans <= 2'h2;
    i_hwrite <= wr;
    i_hsize <= 3'h2;
    wait_ready();
    @(posedge i_core_clk);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_ready();
    rdv = o_hrdata;
    @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask,
                        input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk_word(x, exp, mask, what);
  endtask

  // Only valid calendar values are ever loaded
  task automatic set_time(input logic [31:0] d, input logic [31:0] t);
    wr(8'h04, d);
    wr(8'h08, t);
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_SET_TIME});
  endtask

  // Daily alarm at 08:00:1x, any weekday
  // Address stands for a length-prefixed string of 0 to 40 bytes
  task automatic set_alarm(input logic [7:0] ty);
    wr(8'h04, 32'h00FF_FF08);
    wr(8'h08, {16'h0013, 8'hFF, ty});
    wr(8'h0C, {16'h0000, aaddr});
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_SET_ALARM});
  endtask

  task automatic wait_events(input int exp, input int cycles);
    for (int i = 0; i < cycles && events < exp; i++)
      @(posedge i_core_clk);
  endtask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] upd);
    for (int i = 0; i < 8; i++)
      merge[4*i +: 4] = (upd[4*i +: 4] == 4'hF) ? old[4*i +: 4] : upd[4*i +: 4];
  endfunction

  initial
  begin
    i_arst_n = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 32'h0000_0000;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0000_0000;
    code = 8'($urandom(32'h44B6));
    aaddr = 16'($urandom());
    repeat (10) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    @(posedge i_core_clk);
    rd_chk(8'h10, 32'h0001_0100, ALL, "reset date");
    rd_chk(8'h18, 32'h0000_0000, ALL, "reset state");
    chk_word({31'h0, o_hresp}, 32'h0, ALL, "response");
    for (int i = 0; i < 4; i++)
    begin
      set_time(ST_D[i], 32'h5959_0600);
      repeat (5 * TICKS) @(posedge i_core_clk);
      rd_chk(8'h10, EX_D[i], ALL, "rollover date");
      rd_chk(8'h14, (i == 3) ? 32'h5959_0600 : 32'h0000_0000,
             (i == 3) ? ALL : 32'hFF00_FF00, "rollover time");
    end
    set_time(32'hF51F_2FFF, 32'h1FF0_FF00);
    rd_chk(8'h10, merge(32'h9912_3123, 32'hF51F_2FFF), ALL, "partial date");
    rd_chk(8'h14, merge(32'h5959_0600, 32'h1FF0_FF00), 32'hFFF0_FF00, "partial time");
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_READ_TIME});
    rd_chk(8'h04, 32'h9512_2123, ALL, "read date");
    rd_chk(8'h08, 32'h1950_0600, 32'hFFF0_FFFF, "read time");
    for (int t = 0; t < 4; t++)
    begin
      set_alarm(8'(t));
      // Type register updates at the command edge, so look one edge later
      @(posedge i_core_clk);
      chk_word({24'h0, o_alarm_type}, t, ALL, "alarm type");
    end
    set_alarm(bcc_pkg::TYPE_NAMED_FUNCTION_WAKE);
    set_time(32'h9512_2108, 32'h0000_0200);
    wait_events(1, 200);
    chk_count(0, "fired while not enabled");
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_ENABLE});
    set_time(32'h9512_2108, 32'h0000_0200);
    // Seconds units ignored: the tens match must fire well before second 13
    wait_events(1, 88);
    chk_count(1, "alarm fire");
    chk_word({16'h0, o_alarm_addr}, {16'h0, aaddr}, ALL, "alarm address");
    chk_word({24'h0, o_alarm_type}, 32'h02, ALL, "fired type");
    repeat (100) @(posedge i_core_clk);
    chk_count(1, "single fire per match");
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_READ_ALARM});
    rd_chk(8'h04, 32'hFFFF_FF08, ALL, "alarm date");
    rd_chk(8'h08, 32'h001F_FF02, ALL, "alarm time");
    rd_chk(8'h0C, {16'h0001, aaddr}, ALL, "first status");
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_READ_ALARM});
    rd_chk(8'h0C, {16'h0000, aaddr}, ALL, "second status");
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_DISABLE});
    set_time(32'h9512_2108, 32'h0000_0200);
    wait_events(2, 150);
    chk_count(1, "fired after disable");
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_ENABLE});
    set_time(32'h9512_2108, 32'h0000_0200);
    wait_events(2, 150);
    chk_count(1, "enable without rewrite");
    set_alarm(bcc_pkg::TYPE_ROUTINE_CALL_WAKE);
    wr(8'h00, {24'h00_0000, bcc_pkg::CMD_ENABLE});
    set_time(32'h9512_2108, 32'h0000_0200);
    wait_events(2, 150);
    chk_count(2, "fire after rewrite");
    rd_chk(8'h18, 32'h0000_0004, 32'h0000_0004, "flag set");
    set_alarm(bcc_pkg::TYPE_MESSAGE);
    rd_chk(8'h18, 32'h0000_0000, 32'h0000_0004, "flag cleared");
    desc = $urandom();
    wr(8'h04, desc);
    for (int k = 0; k < 4; k++)
    begin
      code = 8'($urandom());
      while (code inside {8'h00, 8'hFF, 8'h80, 8'h81, 8'h82, 8'h84})
        code = 8'($urandom());
      wr(8'h00, {24'h00_0000, code});
      rd_chk(8'h04, desc, ALL, "unknown command");
      rd_chk(8'h10, 32'h9512_2108, ALL, "unknown command date");
    end
    wr(8'h20, $urandom());
    rd_chk(8'h20, 32'h0000_0000, ALL, "unmapped");
    wrap_up();
  end

  // Guard against a hang anywhere in the sequence
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
